/* logic/vic_top.sv */
// How it works
// - Eight equal return-address entries allow eight levels of nesting.
// - PC is pushed on interrupt entry, call and table lookup.
// - A 3-bit level pointer tracks the entry; its value is readable.
// - Pointer is 7 after reset or wake; push increments first, wrapping.
// - Interrupt entry saves context in one save stage; calls do not.
// - The skip flag is kept in the save stage across the service.
// - PC steps by one, or loads a target on jump, call, return, lookup.
// - PC is page over a 7-bit offset; offset 127 steps to next page.
// - Interrupt loads the source vector in page 1 into the PC.
// - Special-page call reaches page 2 routines from any page.
// - Taken only with request flag, source enable and global enable.
// - Global enable set by enable, cleared by disable and by entry.
// - Source enable picks interrupt or skip test for that source.
// - Request flags set even when disabled and hold until cleared.
// - Flag clears when its interrupt is taken or its skip test skips.
// - Pending sources are served in fixed priority, lowest index first.
// - Vector offsets are 0,2,4,6,8,A,C for the first seven sources.
// - Serial completion is lowest priority, vector offset E.
// - Enable 1 allows interrupt, kills skip test; 0 the reverse.
// - Entry occurs 2 cycles after conditions, 3 in multi-cycle ones.
// - Enable takes effect only after one further instruction.
//
// Strobed register access and the register offsets were decided locally.
`include "vic_cfg.svh"

module vic_top #(
    parameter int PC_W = 13,
    parameter int DP_W = 10,
    parameter int NSRC = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic backup_wake,
    input wire logic instr_valid,
    input wire vic_pkg::vic_op_e instr_op,
    input wire logic [PC_W-1:0] instr_target,
    input wire logic instr_multi,
    input wire logic [2:0] instr_src,
    input wire logic [NSRC-1:0] src_event,
    input wire logic [DP_W-1:0] cpu_dp,
    input wire logic cpu_carry,
    input wire logic cpu_skip,
    input wire logic [3:0] cpu_acc,
    input wire logic [3:0] cpu_regb,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [PC_W-1:0] pc,
    output logic irq_take,
    output logic [2:0] irq_src,
    output logic skip_taken,
    output logic [3:0] sp_to_acc,
    output logic ctx_restore,
    output logic [DP_W-1:0] ctx_dp,
    output logic ctx_carry,
    output logic ctx_skip,
    output logic [3:0] ctx_acc,
    output logic [3:0] ctx_regb
);
    if (PC_W < 9 || PC_W > 16 || NSRC != 8) begin : g_chk
        $error("vic_top: PC must hold page 2 and fit 16 bits; exactly eight sources");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [NSRC-1:0] req_r, req_nxt;
    logic [NSRC-1:0] en_r, en_nxt;
    logic gie_r, gie_nxt;
    logic gie_arm_r, gie_arm_nxt;
    logic [1:0] lat_r, lat_nxt;
    logic [DP_W-1:0] sv_dp_r, sv_dp_nxt;
    logic sv_carry_r, sv_carry_nxt;
    logic sv_skip_r, sv_skip_nxt;
    logic [3:0] sv_acc_r, sv_acc_nxt;
    logic [3:0] sv_regb_r, sv_regb_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] spacc_r, spacc_nxt;
    logic skip_r, skip_nxt;

    logic [NSRC-1:0] live;
    logic cond_any;
    logic [2:0] win;
    logic take;
    logic exec;
    logic push, pop;
    logic [PC_W-1:0] stack_top;
    logic [2:0] sp_level;
    logic [PC_W-1:0] ret_addr;

    // Lowest index wins; index order equals priority order
    function automatic logic [2:0] prio_pick(input logic [NSRC-1:0] v);
        prio_pick = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                prio_pick = 3'(i);
            end
        end
    endfunction

    // Vector address: page 1, two words per source
    function automatic logic [PC_W-1:0] vec_addr(input logic [2:0] s);
        logic [15:0] a;
        a = `VIC_VEC_BASE + {12'h000, s, 1'b0};
        vec_addr = a[PC_W-1:0];
    endfunction

    // ---------------------------------------------------------------
    // Interrupt decision
    // ---------------------------------------------------------------
    assign live = req_r & en_r;
    assign cond_any = gie_r && (live != '0);
    assign win = prio_pick(live);
    // Taken on the third (or fourth) cycle the conditions stand
    assign take = cond_any && (lat_r == 2'h1);
    // The sequencer's instruction in the entry cycle is not executed
    assign exec = instr_valid && !take;
    assign push = take || (exec && (instr_op == vic_pkg::VIC_OP_CALL ||
        instr_op == vic_pkg::VIC_OP_SPCALL || instr_op == vic_pkg::VIC_OP_TABLE));
    assign pop = exec && (instr_op == vic_pkg::VIC_OP_RET || instr_op == vic_pkg::VIC_OP_RETI);
    // Entry replays the dropped instruction; a call resumes at the one after it
    assign ret_addr = take ? pc_r : pc_r + {{(PC_W-1){1'b0}}, 1'b1};

    vic_stack #(
        .DEPTH(8),
        .DW(PC_W)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .level_init(backup_wake),
        .push(push),
        .pop(pop),
        .push_data(ret_addr),
        .top_data(stack_top),
        .level(sp_level)
    );

    // ---------------------------------------------------------------
    // Latency counter
    // ---------------------------------------------------------------
    always_comb begin
        lat_nxt = 2'h0;
        if (cond_any && !take) begin
            if (lat_r == 2'h0) begin
                lat_nxt = instr_multi ? `VIC_LAT_MULTI : `VIC_LAT_SINGLE;
            end else begin
                lat_nxt = lat_r - 2'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Program counter
    // ---------------------------------------------------------------
    always_comb begin
        logic [15:0] sp_call;
        sp_call = `VIC_SPCALL_BASE + {9'h000, instr_target[`VIC_PC_OFS_W-1:0]};
        pc_nxt = pc_r;
        if (take) begin
            pc_nxt = vec_addr(win);
        end else if (exec) begin
            case (instr_op)
                vic_pkg::VIC_OP_BRANCH,
                vic_pkg::VIC_OP_CALL,
                vic_pkg::VIC_OP_TABLE: begin
                    pc_nxt = instr_target;
                end
                vic_pkg::VIC_OP_SPCALL: begin
                    pc_nxt = sp_call[PC_W-1:0];
                end
                vic_pkg::VIC_OP_RET,
                vic_pkg::VIC_OP_RETI: begin
                    pc_nxt = stack_top;
                end
                default: begin
                    // Plain carry out of the offset field steps the page
                    pc_nxt = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Flags, enables and global enable
    // ---------------------------------------------------------------
    always_comb begin
        req_nxt = req_r;
        en_nxt = en_r;
        gie_nxt = gie_r;
        gie_arm_nxt = gie_arm_r;
        skip_nxt = 1'b0;
        spacc_nxt = spacc_r;
        if (take) begin
            req_nxt[win] = 1'b0;
            gie_nxt = 1'b0;
            gie_arm_nxt = 1'b0;
        end else if (exec) begin
            // Enable arms now and opens after the next instruction
            if (gie_arm_r) begin
                gie_nxt = 1'b1;
                gie_arm_nxt = 1'b0;
            end
            case (instr_op)
                vic_pkg::VIC_OP_EI: begin
                    gie_arm_nxt = 1'b1;
                end
                vic_pkg::VIC_OP_DI: begin
                    gie_nxt = 1'b0;
                    gie_arm_nxt = 1'b0;
                end
                vic_pkg::VIC_OP_SKIPTEST: begin
                    if (req_r[instr_src] && !en_r[instr_src]) begin
                        skip_nxt = 1'b1;
                        req_nxt[instr_src] = 1'b0;
                    end
                end
                vic_pkg::VIC_OP_READSP: begin
                    spacc_nxt = {1'b0, sp_level};
                end
                default: begin
                end
            endcase
        end
        if (reg_wr) begin
            if (reg_addr == `VIC_OFS_EN_LOW) begin
                en_nxt[3:0] = reg_wdata[3:0];
            end else if (reg_addr == `VIC_OFS_EN_HIGH) begin
                en_nxt[7:4] = reg_wdata[3:0];
            end
        end
        if (backup_wake) begin
            en_nxt = '0;
        end
        // Events win over any clear in the same cycle
        req_nxt = req_nxt | src_event;
    end

    // ---------------------------------------------------------------
    // Context save stage, used only by interrupt entry
    // ---------------------------------------------------------------
    always_comb begin
        sv_dp_nxt = sv_dp_r;
        sv_carry_nxt = sv_carry_r;
        sv_skip_nxt = sv_skip_r;
        sv_acc_nxt = sv_acc_r;
        sv_regb_nxt = sv_regb_r;
        if (take) begin
            sv_dp_nxt = cpu_dp;
            sv_carry_nxt = cpu_carry;
            sv_skip_nxt = cpu_skip;
            sv_acc_nxt = cpu_acc;
            sv_regb_nxt = cpu_regb;
        end
    end

    // ---------------------------------------------------------------
    // Register read port
    // ---------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `VIC_OFS_EN_LOW) begin
                rdata_nxt = {4'h0, en_r[3:0]};
            end else if (reg_addr == `VIC_OFS_EN_HIGH) begin
                rdata_nxt = {4'h0, en_r[7:4]};
            end else if (reg_addr == `VIC_OFS_REQ_LOW) begin
                rdata_nxt = {4'h0, req_r[3:0]};
            end else if (reg_addr == `VIC_OFS_REQ_HIGH) begin
                rdata_nxt = {4'h0, req_r[7:4]};
            end else if (reg_addr == `VIC_OFS_STATUS) begin
                rdata_nxt[`VIC_STATUS_GIE_BIT] = gie_r;
                rdata_nxt[`VIC_STATUS_SP_LSB +: 3] = sp_level;
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_r <= '0;
            req_r <= '0;
            en_r <= '0;
            gie_r <= 1'b0;
            gie_arm_r <= 1'b0;
            lat_r <= 2'h0;
            sv_dp_r <= '0;
            sv_carry_r <= 1'b0;
            sv_skip_r <= 1'b0;
            sv_acc_r <= 4'h0;
            sv_regb_r <= 4'h0;
            rdata_r <= 8'h00;
            spacc_r <= 4'h0;
            skip_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            req_r <= req_nxt;
            en_r <= en_nxt;
            gie_r <= gie_nxt;
            gie_arm_r <= gie_arm_nxt;
            lat_r <= lat_nxt;
            sv_dp_r <= sv_dp_nxt;
            sv_carry_r <= sv_carry_nxt;
            sv_skip_r <= sv_skip_nxt;
            sv_acc_r <= sv_acc_nxt;
            sv_regb_r <= sv_regb_nxt;
            rdata_r <= rdata_nxt;
            spacc_r <= spacc_nxt;
            skip_r <= skip_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign pc = pc_r;
    assign irq_take = take;
    assign irq_src = win;
    assign skip_taken = skip_r;
    assign sp_to_acc = spacc_r;
    assign reg_rdata = rdata_r;
    assign ctx_restore = exec && (instr_op == vic_pkg::VIC_OP_RETI);
    assign ctx_dp = sv_dp_r;
    assign ctx_carry = sv_carry_r;
    assign ctx_skip = sv_skip_r;
    assign ctx_acc = sv_acc_r;
    assign ctx_regb = sv_regb_r;
endmodule // vic_top

/* logic/vic_cfg.svh */
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH

// ---------------------------------------------------------------
// Register offsets on the plain register port
// ---------------------------------------------------------------
`define VIC_OFS_EN_LOW 3'h0
`define VIC_OFS_EN_HIGH 3'h1
`define VIC_OFS_REQ_LOW 3'h2
`define VIC_OFS_REQ_HIGH 3'h3
`define VIC_OFS_STATUS 3'h4

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define VIC_STATUS_GIE_BIT 0
`define VIC_STATUS_SP_LSB 1
`define VIC_EN_RESET 4'h0
`define VIC_SP_RESET 3'h7

// ---------------------------------------------------------------
// Address map of program memory
// ---------------------------------------------------------------
`define VIC_PC_OFS_W 7
`define VIC_VEC_BASE 16'h0080
`define VIC_SPCALL_BASE 16'h0100

// ---------------------------------------------------------------
// Interrupt entry latency in machine cycles
// ---------------------------------------------------------------
`define VIC_LAT_SINGLE 2'h2
`define VIC_LAT_MULTI 2'h3

`endif

/* logic/vic_pkg.sv */
package vic_pkg;

    typedef enum logic [3:0] {
        VIC_OP_SEQ,
        VIC_OP_BRANCH,
        VIC_OP_CALL,
        VIC_OP_SPCALL,
        VIC_OP_TABLE,
        VIC_OP_RET,
        VIC_OP_RETI,
        VIC_OP_EI,
        VIC_OP_DI,
        VIC_OP_SKIPTEST,
        VIC_OP_READSP
    } vic_op_e;

endpackage

/* logic/vic_stack.sv */
`include "vic_cfg.svh"

module vic_stack #(
    parameter int DEPTH = 8,
    parameter int DW = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_init,
    input wire logic push,
    input wire logic pop,
    input wire logic [DW-1:0] push_data,
    output logic [DW-1:0] top_data,
    output logic [2:0] level
);
    if (DEPTH != 8) begin : g_chk
        $error("vic_stack: a 3-bit level pointer serves exactly eight entries");
    end

    logic [DW-1:0] entry_r [DEPTH];
    logic [DW-1:0] entry_nxt [DEPTH];
    logic [2:0] level_r;
    logic [2:0] level_nxt;

    // ---------------------------------------------------------------
    // Pointer moves first, then the entry is written
    // ---------------------------------------------------------------
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < DEPTH; i++) begin
            entry_nxt[i] = entry_r[i];
        end
        if (level_init) begin
            level_nxt = `VIC_SP_RESET;
        end else if (push) begin
            // Wraps 7 -> 0, so a ninth nesting overwrites entry 0
            level_nxt = level_r + 3'h1;
            entry_nxt[level_nxt] = push_data;
        end else if (pop) begin
            level_nxt = level_r - 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_r <= `VIC_SP_RESET;
            for (int i = 0; i < DEPTH; i++) begin
                entry_r[i] <= '0;
            end
        end else begin
            level_r <= level_nxt;
            for (int i = 0; i < DEPTH; i++) begin
                entry_r[i] <= entry_nxt[i];
            end
        end
    end

    assign top_data = entry_r[level_r];
    assign level = level_r;
endmodule // vic_stack

/* tb/vic_src_model.sv */
module vic_src_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] cond,
    output logic [7:0] src_event
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // Peripheral activating conditions
    // ------------------------------------------------
    logic [7:0] cond_r;
    logic [7:0] cond_nxt;
    always_comb begin
        cond_nxt = cond;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cond_r <= 8'h00;
        end else begin
            cond_r <= cond_nxt;
        end
    end
    // One pulse per rising condition, so a held level cannot re-set a flag the core just cleared
    assign src_event = cond & ~cond_r;
endmodule // vic_src_model

/* tb/vic_top_properties.sv */
module vic_top_chk #(
    parameter int PC_W = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire vic_pkg::vic_op_e instr_op,
    input wire logic [PC_W-1:0] instr_target,
    input wire logic [PC_W-1:0] pc,
    input wire logic irq_take,
    input wire logic [2:0] irq_src,
    input wire logic skip_taken,
    input wire logic [3:0] sp_to_acc,
    input wire logic ctx_restore
);
    // ------------------------------------------------
    // Sequencing properties
    // ------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic go;
    // An instruction in the entry cycle is dropped and replayed
    assign go = instr_valid && !irq_take;
    seq_step_a:
    assert property (go && instr_op == vic_pkg::VIC_OP_SEQ |=> pc == $past(pc) + 1'b1) else $error("pc step wrong");
    jump_load_a:
    assert property (go && instr_op inside {vic_pkg::VIC_OP_BRANCH, vic_pkg::VIC_OP_CALL, vic_pkg::VIC_OP_TABLE}
        |=> pc == $past(instr_target)) else $error("jump target wrong");
    special_call_a:
    assert property (go && instr_op == vic_pkg::VIC_OP_SPCALL
        |=> pc[6:0] == $past(instr_target[6:0]) && pc[PC_W-1:7] == 2) else $error("special call wrong");
    vector_load_a:
    assert property (irq_take |=> pc == 13'h080 + {$past(irq_src), 1'b0}) else $error("vector wrong");
    single_entry_a:
    assert property (irq_take |=> !irq_take [*3]) else $error("entry repeated");
    skip_cause_a:
    assert property (skip_taken |-> $past(go && instr_op == vic_pkg::VIC_OP_SKIPTEST)) else $error("stray skip");
    level_hold_a:
    assert property (!(go && instr_op == vic_pkg::VIC_OP_READSP) |=> $stable(sp_to_acc)) else $error("level copy moved");
    ctx_return_a:
    assert property (ctx_restore == (go && instr_op == vic_pkg::VIC_OP_RETI)) else $error("restore wrong");
    cover property (irq_take);
    cover property (skip_taken);
    cover property (ctx_restore);
endmodule // vic_top_chk

bind vic_top vic_top_chk #(.PC_W(PC_W)) i_chk (.clk, .rst, .instr_valid, .instr_op, .instr_target, .pc,
    .irq_take, .irq_src, .skip_taken, .sp_to_acc, .ctx_restore);

/* tb/testbench.sv */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------
    typedef struct {vic_pkg::vic_op_e op; logic [12:0] tgt; logic [12:0] pc;} vic_row_s;
    vic_row_s rows [6] = '{'{vic_pkg::VIC_OP_SEQ, 13'h0000, 13'h0001}, '{vic_pkg::VIC_OP_BRANCH, 13'h007f, 13'h007f},
        '{vic_pkg::VIC_OP_SEQ, 13'h0000, 13'h0080}, '{vic_pkg::VIC_OP_SPCALL, 13'h1e15, 13'h0115},
        '{vic_pkg::VIC_OP_CALL, 13'h0abc, 13'h0abc}, '{vic_pkg::VIC_OP_TABLE, 13'h1300, 13'h1300}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic backup_wake = 1'b0;
    logic instr_valid = 1'b0;
    vic_pkg::vic_op_e instr_op = vic_pkg::VIC_OP_SEQ;
    logic [12:0] instr_target = 13'h0000;
    logic instr_multi = 1'b0;
    logic [2:0] instr_src = 3'h0;
    logic [7:0] cond = 8'h00;
    logic [7:0] src_event;
    logic [9:0] cpu_dp = 10'h2a5;
    logic cpu_carry = 1'b1;
    logic cpu_skip = 1'b1;
    logic [3:0] cpu_acc = 4'h9;
    logic [3:0] cpu_regb = 4'h6;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [12:0] pc;
    logic irq_take;
    logic [2:0] irq_src;
    logic skip_taken;
    logic [3:0] sp_to_acc;
    logic ctx_restore;
    logic [9:0] ctx_dp;
    logic ctx_carry;
    logic ctx_skip;
    logic [3:0] ctx_acc;
    logic [3:0] ctx_regb;
    logic [7:0] d;
    int n;
    int failures = 0;
    int n_checks = 0;

    vic_src_model i_src (.clk, .rst, .cond, .src_event);
    vic_top i_dut (.clk, .rst, .backup_wake, .instr_valid, .instr_op, .instr_target, .instr_multi, .instr_src,
        .src_event, .cpu_dp, .cpu_carry, .cpu_skip, .cpu_acc, .cpu_regb, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pc, .irq_take, .irq_src, .skip_taken, .sp_to_acc, .ctx_restore, .ctx_dp,
        .ctx_carry, .ctx_skip, .ctx_acc, .ctx_regb);

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic ins(input vic_pkg::vic_op_e op, input logic [12:0] tgt);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_target <= tgt;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        cond <= m;
        @(posedge clk);
        cond <= 8'h00;
    endtask

    task automatic wait_take(output int k);
        k = 0;
        while (irq_take !== 1'b1) begin
            @(posedge clk);
            #1;
            k++;
            if (k > 8) begin
                failures++;
                close_out();
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(3'h4, d);
        `CHK(d, 8'h0e)
        foreach (rows[i]) begin
            ins(rows[i].op, rows[i].tgt);
            `CHK(pc, rows[i].pc)
        end
        ins(vic_pkg::VIC_OP_READSP, 13'h0000);
        `CHK(sp_to_acc, 4'h2)
        repeat (6) ins(vic_pkg::VIC_OP_CALL, 13'h0400);
        rd(3'h4, d);
        `CHK(d, 8'h00)
        ins(vic_pkg::VIC_OP_RET, 13'h0000);
        `CHK(pc, 13'h0401)
        ins(vic_pkg::VIC_OP_READSP, 13'h0000);
        `CHK(sp_to_acc, 4'h7)
        // Sources 2 and 5 stay pending so the passes for sources 0 to 4 also test priority
        wr(3'h0, 8'hff);
        wr(3'h1, 8'h0f);
        rd(3'h0, d);
        `CHK(d, 8'h0f)
        pulse(8'h24);
        rd(3'h2, d);
        `CHK(d, 8'h04)
        rd(3'h3, d);
        `CHK(d, 8'h02)
        for (int s = 0; s < 8; s++) begin
            pulse(8'h01 << s);
            instr_multi <= (s == 7);
            ins(vic_pkg::VIC_OP_EI, 13'h0000);
            ins(vic_pkg::VIC_OP_SEQ, 13'h0000);
            wait_take(n);
            `CHK(n, (s == 7) ? 2 + 1 : 2)
            `CHK(irq_src, 3'(s))
            @(posedge clk);
            instr_multi <= 1'b0;
            #1;
            `CHK(pc, 13'h080 + 13'(2 * s))
            if (s == 0) begin
                rd(3'h2, d);
                `CHK(d, 8'h04)
                rd(3'h4, d);
                `CHK(d[0], 1'b0)
            end
        end
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= vic_pkg::VIC_OP_RETI;
        #1;
        `CHK(ctx_restore, 1'b1)
        `CHK(({ctx_dp, ctx_carry, ctx_skip, ctx_acc, ctx_regb}), ({10'h2a5, 1'b1, 1'b1, 4'h9, 4'h6}))
        @(posedge clk);
        instr_valid <= 1'b0;
        // Skip test path: source 0 masked, global enable open
        wr(3'h0, 8'h0e);
        pulse(8'h01);
        ins(vic_pkg::VIC_OP_EI, 13'h0000);
        ins(vic_pkg::VIC_OP_SEQ, 13'h0000);
        repeat (4) begin
            @(posedge clk);
            #1;
            `CHK(irq_take, 1'b0)
        end
        ins(vic_pkg::VIC_OP_SKIPTEST, 13'h0000);
        `CHK(skip_taken, 1'b1)
        rd(3'h2, d);
        `CHK(d, 8'h00)
        ins(vic_pkg::VIC_OP_DI, 13'h0000);
        wr(3'h0, 8'h0f);
        pulse(8'h01);
        ins(vic_pkg::VIC_OP_SKIPTEST, 13'h0000);
        `CHK(skip_taken, 1'b0)
        wr(3'h2, 8'h00);
        rd(3'h2, d);
        `CHK(d, 8'h01)
        rd(3'h6, d);
        `CHK(d, 8'h00)
        @(posedge clk);
        backup_wake <= 1'b1;
        @(posedge clk);
        backup_wake <= 1'b0;
        rd(3'h4, d);
        `CHK(d, 8'h0e)
        rd(3'h0, d);
        `CHK(d, 8'h00)
        close_out();
    end
endmodule // testbench
